// *** verilog/ptg_pkg.sv ***
// ptg_pkg: constants, register map and types for the pulse train output block
// assumes: one 40 MHz system clock, 16-bit register port, two pulse channels

package ptg_pkg;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int unsigned PTG_CLK_HZ = 40_000_000;
  localparam int unsigned PTG_MAX_FREQ_HZ = 200_000;

  // ----------------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------------
  localparam int PTG_ADDR_W = 5;
  localparam int PTG_DATA_W = 16;
  localparam int PTG_CH_N = 2;
  localparam int PTG_WIDE_W = 32;
  localparam int PTG_ACC_W = 34;

  // ----------------------------------------------------------------------
  // register map, word addresses; channel 1 sits one stride above channel 0
  // ----------------------------------------------------------------------
  localparam logic [4:0] PTG_CH_STRIDE = 5'h08;
  localparam logic [4:0] PTG_OFS_FREQ_LO = 5'h00;
  localparam logic [4:0] PTG_OFS_FREQ_HI = 5'h01;
  localparam logic [4:0] PTG_OFS_QTY_LO = 5'h02;
  localparam logic [4:0] PTG_OFS_QTY_HI = 5'h03;
  localparam logic [4:0] PTG_OFS_CTRL = 5'h04;
  localparam logic [4:0] PTG_OFS_STAT = 5'h05;
  localparam logic [4:0] PTG_OFS_CNT_LO = 5'h06;
  localparam logic [4:0] PTG_OFS_CNT_HI = 5'h07;
  localparam logic [4:0] PTG_ADR_CH0_TOTAL_LO = 5'h10;
  localparam logic [4:0] PTG_ADR_CH0_TOTAL_HI = 5'h11;
  localparam logic [4:0] PTG_ADR_CH1_TOTAL_LO = 5'h12;
  localparam logic [4:0] PTG_ADR_CH1_TOTAL_HI = 5'h13;
  localparam logic [4:0] PTG_ADR_BOTH_TOTAL_LO = 5'h14;
  localparam logic [4:0] PTG_ADR_BOTH_TOTAL_HI = 5'h15;
  localparam logic [4:0] PTG_ADR_FLAGS = 5'h16;

  // ----------------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------------
  localparam int PTG_CTRL_WIDE_BIT = 0;
  localparam int PTG_CTRL_STOP_BIT = 1;
  localparam int PTG_STAT_BUSY_BIT = 0;
  localparam int PTG_STAT_LEVEL_BIT = 1;
  localparam int PTG_STAT_HOLD_BIT = 2;
  localparam int PTG_STAT_DRIVE_BIT = 3;
  localparam int PTG_FLAG_DONE_BIT = 0;
  localparam logic [15:0] PTG_RST_FREQ = 16'h0001;
  localparam logic [15:0] PTG_RST_QTY = 16'h0001;

  // ----------------------------------------------------------------------
  // channel state
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    PTG_IDLE = 3'b001,
    PTG_RUN = 3'b010,
    PTG_HOLD = 3'b100
  } ptg_state_e;

endpackage : ptg_pkg

// *** verilog/ptg_top.sv ***
// ptg_top: two-channel pulse train generator with pulse totals
// assumes: drive inputs come from logic on sys_clk_i; registers on a plain
// strobe port with read data one cycle after the read strobe

`timescale 1ns/1ps

module ptg_top #(
  parameter int unsigned CLK_HZ = ptg_pkg::PTG_CLK_HZ
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [ptg_pkg::PTG_CH_N-1:0] drive_i,
  input wire logic [ptg_pkg::PTG_ADDR_W-1:0] reg_addr_i,
  input wire logic [ptg_pkg::PTG_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [ptg_pkg::PTG_DATA_W-1:0] reg_rdata_o,
  output logic pulse_out_ch0_o,
  output logic pulse_out_ch1_o,
  output logic busy_flag_ch0_o,
  output logic busy_flag_ch1_o,
  output logic completion_flag_o
);
  import ptg_pkg::*;

  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  if (CLK_HZ < 2 * PTG_MAX_FREQ_HZ) begin : g_clk_check
    $error("CLK_HZ too low for the top output frequency");
  end
  // the limit is worked out in 64 bits so that the shift cannot wrap
  if (64'(CLK_HZ) >= (64'h1 << (PTG_ACC_W - 2))) begin : g_acc_check
    $error("CLK_HZ too wide for the phase accumulator");
  end
  // reset values, outputs and the total adder are laid out for two channels
  if (PTG_CH_N != 2) begin : g_ch_check
    $error("the block serves exactly two pulse channels");
  end
  // operands and totals are built from two register words
  if (PTG_WIDE_W != 2 * PTG_DATA_W) begin : g_word_check
    $error("wide operands must be two register words");
  end

  // ----------------------------------------------------------------------
  // half period timing
  // ----------------------------------------------------------------------
  // every clock the accumulator of a running channel grows by twice the
  // frequency; once it reaches the clock rate one half period is over and
  // the output toggles. the overshoot is kept, so rates that do not divide
  // the clock evenly jitter by one cycle but keep their average.
  // the step is read afresh each clock, so a new frequency acts at once.
  // a frequency of zero freezes the output where it stands.
  // the top rate still leaves at least one clock per half period.

  localparam logic [PTG_ACC_W-1:0] CLK_LIM = PTG_ACC_W'(CLK_HZ);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [PTG_CH_N-1:0][15:0] freq_lo;
    logic [PTG_CH_N-1:0][15:0] freq_hi;
    logic [PTG_CH_N-1:0][15:0] qty_lo;
    logic [PTG_CH_N-1:0][15:0] qty_hi;
    logic [PTG_CH_N-1:0] wide;
    logic [PTG_CH_N-1:0] stop_req;
    ptg_state_e [PTG_CH_N-1:0] st;
    logic [PTG_CH_N-1:0] level;
    logic [PTG_CH_N-1:0] drive;
    logic [PTG_CH_N-1:0][PTG_ACC_W-1:0] acc;
    logic [PTG_CH_N-1:0][31:0] cnt;
    logic [PTG_CH_N-1:0][31:0] qty;
    logic [PTG_CH_N-1:0][31:0] total;
    logic [31:0] both_total;
    logic done;
    logic [15:0] rdata;
  } ptg_regs_s;

  // per channel: idle waits for a rising drive, run emits pulses, hold
  // keeps the output low after a finish or a stop until the drive drops.
  // the drive is sampled each clock, so a start needs a fresh rising edge;
  // this keeps a busy or parked channel from being restarted.

  ptg_regs_s q;
  ptg_regs_s d;

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  // word map: channel 0 at 0x00, channel 1 at 0x08, each with
  //   +0 frequency low, +1 frequency high, +2 quantity low,
  //   +3 quantity high, +4 control (wide, stop), +5 status (read only),
  //   +6 run count low, +7 run count high (read only)
  // pulse totals: 0x10/0x11 channel 0, 0x12/0x13 channel 1,
  //   0x14/0x15 both channels, 0x16 flags (completion, read only)
  // every total is a pair of separate words; software clears one by
  // writing zero to both halves, and a pulse between the two writes
  // is counted into whatever the other half then holds.

  // hit on one word of a channel block
  function automatic logic ptg_hit(input logic [4:0] addr, input int ch,
                                   input logic [4:0] ofs);
    logic [4:0] base;
    base = ch[0] ? PTG_CH_STRIDE : 5'h00;
    return addr == (base | ofs);
  endfunction : ptg_hit

  // address of the low or high word of a channel total
  function automatic logic [4:0] ptg_tot_adr(input int ch, input logic hi);
    logic [4:0] a;
    a = ch[0] ? PTG_ADR_CH1_TOTAL_LO : PTG_ADR_CH0_TOTAL_LO;
    return hi ? (a | 5'h01) : a;
  endfunction : ptg_tot_adr

  // 32-bit operand from a word pair; narrow mode leaves the high word out
  function automatic logic [31:0] ptg_join(input logic wide, input logic [15:0] hi,
                                           input logic [15:0] lo);
    logic [31:0] w;
    w = {16'h0000, lo};
    if (wide) begin
      w = {hi, lo};
    end
    return w;
  endfunction : ptg_join

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  // fell marks a pulse whose high half times out this cycle, start a fresh rising drive;
  // fell feeds the totals and start the run control of the same cycle
  logic [PTG_CH_N-1:0] fell;
  logic [PTG_CH_N-1:0][31:0] freq_eff;
  logic [PTG_CH_N-1:0][31:0] qty_eff;
  logic [PTG_CH_N-1:0][PTG_ACC_W-1:0] acc_sum;
  logic [PTG_CH_N-1:0][31:0] cnt_inc;
  logic [PTG_CH_N-1:0] start;
  logic done_set;
  logic done_clr;
  logic [31:0] both_t;
  logic [1:0] fall_n;

  always_comb begin
    d = q;
    d.rdata = 16'h0000;
    fell = '0;
    done_set = 1'b0;
    done_clr = 1'b0;
    freq_eff = '0;
    qty_eff = '0;
    acc_sum = '0;
    cnt_inc = '0;
    start = '0;
    both_t = q.both_total;
    fall_n = 2'b00;

    for (int i = 0; i < PTG_CH_N; i++) begin
      // register writes
      if (reg_we_i) begin
        if (ptg_hit(reg_addr_i, i, PTG_OFS_FREQ_LO)) begin
          d.freq_lo[i] = reg_wdata_i;
        end else if (ptg_hit(reg_addr_i, i, PTG_OFS_FREQ_HI)) begin
          d.freq_hi[i] = reg_wdata_i;
        end else if (ptg_hit(reg_addr_i, i, PTG_OFS_QTY_LO)) begin
          d.qty_lo[i] = reg_wdata_i;
        end else if (ptg_hit(reg_addr_i, i, PTG_OFS_QTY_HI)) begin
          d.qty_hi[i] = reg_wdata_i;
        end else if (ptg_hit(reg_addr_i, i, PTG_OFS_CTRL)) begin
          d.wide[i] = reg_wdata_i[PTG_CTRL_WIDE_BIT];
          d.stop_req[i] = reg_wdata_i[PTG_CTRL_STOP_BIT];
        end else if (reg_addr_i == ptg_tot_adr(i, 1'b0)) begin
          d.total[i][15:0] = reg_wdata_i;
        end else if (reg_addr_i == ptg_tot_adr(i, 1'b1)) begin
          d.total[i][31:16] = reg_wdata_i;
        end
      end

      freq_eff[i] = ptg_join(q.wide[i], q.freq_hi[i], q.freq_lo[i]);
      qty_eff[i] = ptg_join(q.wide[i], q.qty_hi[i], q.qty_lo[i]);

      // phase step of twice the frequency, wrapping at the clock rate
      acc_sum[i] = q.acc[i] + {1'b0, freq_eff[i], 1'b0};
      cnt_inc[i] = q.cnt[i] + 32'h0000_0001;
      // drive comes from logic on this clock, so it needs no synchroniser
      d.drive[i] = drive_i[i];
      start[i] = drive_i[i] & ~q.drive[i];

      case (q.st[i])
        PTG_IDLE: begin
          // a start needs a fresh rising drive while idle
          if (start[i]) begin
            done_clr = 1'b1;
            d.cnt[i] = 32'h0000_0000;
            d.acc[i] = '0;
            d.qty[i] = qty_eff[i];
            if (q.stop_req[i]) begin
              // stop bit already set: straight to hold, no pulse at all
              d.st[i] = PTG_HOLD;
              d.level[i] = 1'b0;
            end else begin
              d.st[i] = PTG_RUN;
              d.level[i] = 1'b1;
            end
          end
        end
        PTG_RUN: begin
          // a dropped drive beats a stop request, which beats the timing
          if (!drive_i[i]) begin
            d.st[i] = PTG_IDLE;
            d.level[i] = 1'b0;
            done_clr = 1'b1;
          end else if (q.stop_req[i]) begin
            d.st[i] = PTG_HOLD;
            d.level[i] = 1'b0;
            done_clr = 1'b1;
          end else if (acc_sum[i] >= CLK_LIM) begin
            // half period over: reload by taking one clock second away
            d.acc[i] = acc_sum[i] - CLK_LIM;
            // a step of a whole clock or more would never wrap back: restart
            if (d.acc[i] >= CLK_LIM) begin
              d.acc[i] = '0;
            end
            if (q.level[i]) begin
              d.level[i] = 1'b0;
              d.cnt[i] = cnt_inc[i];
              fell[i] = 1'b1;
              if (q.qty[i] != 32'h0000_0000 && cnt_inc[i] == q.qty[i]) begin
                d.st[i] = PTG_HOLD;
                done_set = 1'b1;
              end
            end else begin
              d.level[i] = 1'b1;
            end
          end else begin
            d.acc[i] = acc_sum[i];
          end
        end
        PTG_HOLD: begin
          // finished or stopped; waits for the drive to drop
          // the run count stays readable here until the next start
          d.level[i] = 1'b0;
          if (!drive_i[i]) begin
            d.st[i] = PTG_IDLE;
          end
        end
        default: begin
          d.st[i] = PTG_IDLE;
          d.level[i] = 1'b0;
        end
      endcase

      // a write and a pulse in one cycle: write first, then count,
      // so a written word is never lost and the pulse still lands on top
      if (fell[i]) begin
        d.total[i] = d.total[i] + 32'h0000_0001;
      end
    end

    // grand total
    if (reg_we_i && reg_addr_i == PTG_ADR_BOTH_TOTAL_LO) begin
      both_t[15:0] = reg_wdata_i;
    end else if (reg_we_i && reg_addr_i == PTG_ADR_BOTH_TOTAL_HI) begin
      both_t[31:16] = reg_wdata_i;
    end
    fall_n = {1'b0, fell[0]} + {1'b0, fell[1]};
    d.both_total = both_t + {30'h0000_0000, fall_n};

    // one completion flag serves both channels; it answers for the run
    // that finished or stopped last
    // completion flag: a finish in the same cycle beats a clear
    if (done_set) begin
      d.done = 1'b1;
    end else if (done_clr) begin
      d.done = 1'b0;
    end

    // ----------------------------------------------------------------------
    // register reads, data stand one cycle after the strobe
    // ----------------------------------------------------------------------
    // status word: busy, output level, hold, sampled drive; control word
    // reads back wide and stop; unmapped words and unused bits read zero
    if (reg_re_i) begin
      for (int i = 0; i < PTG_CH_N; i++) begin
        if (ptg_hit(reg_addr_i, i, PTG_OFS_FREQ_LO)) begin
          d.rdata = q.freq_lo[i];
        end else if (ptg_hit(reg_addr_i, i, PTG_OFS_FREQ_HI)) begin
          d.rdata = q.freq_hi[i];
        end else if (ptg_hit(reg_addr_i, i, PTG_OFS_QTY_LO)) begin
          d.rdata = q.qty_lo[i];
        end else if (ptg_hit(reg_addr_i, i, PTG_OFS_QTY_HI)) begin
          d.rdata = q.qty_hi[i];
        end else if (ptg_hit(reg_addr_i, i, PTG_OFS_CTRL)) begin
          d.rdata[PTG_CTRL_WIDE_BIT] = q.wide[i];
          d.rdata[PTG_CTRL_STOP_BIT] = q.stop_req[i];
        end else if (ptg_hit(reg_addr_i, i, PTG_OFS_STAT)) begin
          d.rdata[PTG_STAT_BUSY_BIT] = (q.st[i] == PTG_RUN);
          d.rdata[PTG_STAT_LEVEL_BIT] = q.level[i];
          d.rdata[PTG_STAT_HOLD_BIT] = (q.st[i] == PTG_HOLD);
          d.rdata[PTG_STAT_DRIVE_BIT] = q.drive[i];
        end else if (ptg_hit(reg_addr_i, i, PTG_OFS_CNT_LO)) begin
          d.rdata = q.cnt[i][15:0];
        end else if (ptg_hit(reg_addr_i, i, PTG_OFS_CNT_HI)) begin
          d.rdata = q.cnt[i][31:16];
        end else if (reg_addr_i == ptg_tot_adr(i, 1'b0)) begin
          d.rdata = q.total[i][15:0];
        end else if (reg_addr_i == ptg_tot_adr(i, 1'b1)) begin
          d.rdata = q.total[i][31:16];
        end
      end
      if (reg_addr_i == PTG_ADR_BOTH_TOTAL_LO) begin
        d.rdata = q.both_total[15:0];
      end else if (reg_addr_i == PTG_ADR_BOTH_TOTAL_HI) begin
        d.rdata = q.both_total[31:16];
      end else if (reg_addr_i == PTG_ADR_FLAGS) begin
        d.rdata[PTG_FLAG_DONE_BIT] = q.done;
      end
    end
  end

  // ----------------------------------------------------------------------
  // state register; the generator runs every clock, not per program scan
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    // frequency and quantity low words come up at one, so a start
    // straight after reset still gives one defined pulse
    if (rst_i) begin
      q <= '0;
      for (int i = 0; i < PTG_CH_N; i++) begin
        q.st[i] <= PTG_IDLE;
        q.freq_lo[i] <= PTG_RST_FREQ;
        q.qty_lo[i] <= PTG_RST_QTY;
      end
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  // pulse outputs idle low and are plain register bits; busy covers the
  // run state only; an idle channel takes a new start, a held one only after its drive drops
  assign reg_rdata_o = q.rdata;
  assign pulse_out_ch0_o = q.level[0];
  assign pulse_out_ch1_o = q.level[1];
  assign busy_flag_ch0_o = (q.st[0] == PTG_RUN);
  assign busy_flag_ch1_o = (q.st[1] == PTG_RUN);
  assign completion_flag_o = q.done;

endmodule : ptg_top

// *** verification/ptg_checker.sv ***
// ptg_checker: port-level assertions for the pulse train block
// assumes: bound into ptg_top, one clock, synchronous active-high reset
`timescale 1ns/1ps
module ptg_checker (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [ptg_pkg::PTG_CH_N-1:0] drive_i,
  input wire logic [ptg_pkg::PTG_ADDR_W-1:0] reg_addr_i,
  input wire logic [ptg_pkg::PTG_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  input wire logic [ptg_pkg::PTG_DATA_W-1:0] reg_rdata_o,
  input wire logic pulse_out_ch0_o,
  input wire logic pulse_out_ch1_o,
  input wire logic busy_flag_ch0_o,
  input wire logic busy_flag_ch1_o,
  input wire logic completion_flag_o
);
  import ptg_pkg::*;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  // ----
  // steps of a run
  // ----
  sequence start0_s;
    $rose(drive_i[0]);
  endsequence
  sequence start1_s;
    $rose(drive_i[1]);
  endsequence
  sequence finish_s;
    $fell(pulse_out_ch0_o) || $fell(pulse_out_ch1_o);
  endsequence
  drop_stops0_a: assert property (!drive_i[0] |=> !pulse_out_ch0_o && !busy_flag_ch0_o)
    else $error("ch0 still active after command dropped");
  drop_stops1_a: assert property (!drive_i[1] |=> !pulse_out_ch1_o && !busy_flag_ch1_o)
    else $error("ch1 still active after command dropped");
  start_ch0_a: assert property (start0_s |=> pulse_out_ch0_o == busy_flag_ch0_o)
    else $error("ch0 start did not raise output with busy");
  start_ch1_a: assert property (start1_s |=> pulse_out_ch1_o == busy_flag_ch1_o)
    else $error("ch1 start did not raise output with busy");
  pulse_busy_a: assert property ((pulse_out_ch0_o -> busy_flag_ch0_o) &&
    (pulse_out_ch1_o -> busy_flag_ch1_o)) else $error("pulse high without busy");
  done_edge_a: assert property ($rose(completion_flag_o) |-> finish_s)
    else $error("completion rose away from a falling pulse");
  early_stop_a: assert property ($fell(drive_i[0]) && busy_flag_ch0_o &&
    !busy_flag_ch1_o |=> !completion_flag_o) else $error("completion set after early stop");
  rdata_idle_a: assert property (!reg_re_i |=> reg_rdata_o == 16'h0000)
    else $error("read data not zero outside read slot");
endmodule : ptg_checker

bind ptg_top ptg_checker i_ptg_checker (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .drive_i(drive_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
  .reg_rdata_o(reg_rdata_o), .pulse_out_ch0_o(pulse_out_ch0_o),
  .pulse_out_ch1_o(pulse_out_ch1_o), .busy_flag_ch0_o(busy_flag_ch0_o),
  .busy_flag_ch1_o(busy_flag_ch1_o), .completion_flag_o(completion_flag_o));

// *** verification/ptg_load_model.sv ***
// ptg_load_model: load on both pulse outputs, counts pulses and half lengths
// assumes: outputs sampled on the system clock
`timescale 1ns/1ps
module ptg_load_model (
  input wire logic clk_i,
  input wire logic clr_i,
  input wire logic [1:0] pulse_i,
  output int rise_cnt_o [2],
  output int hi_len_o [2],
  output int lo_len_o [2]
);
  int run_len [2];
  logic [1:0] last_q;
  always @(posedge clk_i) begin
    for (int i = 0; i < 2; i++) begin
      if (clr_i) begin
        rise_cnt_o[i] <= 0;
        run_len[i] = 0;
      end else if (pulse_i[i] !== last_q[i]) begin
        if (pulse_i[i] === 1'b1) begin
          rise_cnt_o[i] <= rise_cnt_o[i] + 1;
          lo_len_o[i] <= run_len[i];
        end else begin
          hi_len_o[i] <= run_len[i];
        end
        run_len[i] = 1;
      end else begin
        run_len[i] = run_len[i] + 1;
      end
    end
    last_q <= pulse_i;
  end
endmodule : ptg_load_model

// *** verification/tb.sv ***
// tb: register and command level tests of the pulse train block
// assumes: ptg_top with a lowered clock rate so half periods stay short
`timescale 1ns/1ps
module tb;
  import ptg_pkg::*;
  localparam int unsigned CLK_HZ = 1_310_720;
  localparam logic [4:0] C1 = PTG_CH_STRIDE;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic clr = 1'b1;
  logic [1:0] drive = 2'h0;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [15:0] reg_rdata;
  logic pulse0, pulse1, busy0, busy1, done;
  int rises [2];
  int hi_len [2];
  int lo_len [2];
  int fail_count = 0;
  int checks_done = 0;
  always #12.5 sys_clk = ~sys_clk;
  ptg_top #(.CLK_HZ(CLK_HZ)) i_ptg_top (.sys_clk_i(sys_clk), .rst_i(rst), .drive_i(drive),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_we_i(reg_we), .reg_re_i(reg_re),
    .reg_rdata_o(reg_rdata), .pulse_out_ch0_o(pulse0), .pulse_out_ch1_o(pulse1),
    .busy_flag_ch0_o(busy0), .busy_flag_ch1_o(busy1), .completion_flag_o(done));
  ptg_load_model i_ptg_load_model (.clk_i(sys_clk), .clr_i(clr), .pulse_i({pulse1, pulse0}),
    .rise_cnt_o(rises), .hi_len_o(hi_len), .lo_len_o(lo_len));
  // ----
  // tasks
  // ----
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge sys_clk);
    reg_we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [15:0] exp, input string what);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge sys_clk);
    reg_re <= 1'b0;
    #1 check(what, {16'h0000, reg_rdata}, {16'h0000, exp});
  endtask : rd
  task automatic setup(input logic [4:0] b, input logic wide, input logic [31:0] f,
                       input logic [31:0] q);
    wr(b + PTG_OFS_FREQ_LO, f[15:0]);
    wr(b + PTG_OFS_FREQ_HI, f[31:16]);
    wr(b + PTG_OFS_QTY_LO, q[15:0]);
    wr(b + PTG_OFS_QTY_HI, q[31:16]);
    wr(b + PTG_OFS_CTRL, {15'h0000, wide});
  endtask : setup
  task automatic drv(input int ch, input logic v);
    @(posedge sys_clk);
    drive[ch] <= v;
  endtask : drv
  task automatic wait_done(input int n);
    for (int i = 0; i < n && done !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
  endtask : wait_done
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : settle
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run
  // ----
  // tests
  // ----
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    clr <= 1'b0;
    rd(PTG_OFS_FREQ_LO, 16'h0001, "freq reset");
    rd(PTG_ADR_BOTH_TOTAL_HI, 16'h0000, "both total reset");
    wr(5'h1F, 16'hFFFF);
    rd(5'h1F, 16'h0000, "unmapped");
    $display("test reset done");
    setup(5'h00, 1'b0, 32'h0001_2000, 32'h0001_0003);
    drv(0, 1'b1);
    wr(PTG_OFS_QTY_LO, 16'h0009);
    wait_done(2000);
    check("done", {31'h0, done}, 32'h1);
    check("busy0 held", {31'h0, busy0}, 32'h0);
    check("rises0", rises[0], 32'd3);
    check("high half", hi_len[0], 32'd80);
    check("low half", lo_len[0], 32'd80);
    rd(PTG_ADR_CH0_TOTAL_LO, 16'h0003, "ch0 total");
    drv(0, 1'b0);
    drv(0, 1'b1);
    settle(2);
    wait_done(3000);
    check("rises restart", rises[0], 32'd12);
    rd(PTG_ADR_BOTH_TOTAL_LO, 16'h000C, "both total");
    drv(0, 1'b0);
    $display("test counted done");
    setup(C1, 1'b1, 32'h0001_0000, 32'h0000_0004);
    drv(1, 1'b1);
    settle(2);
    wait_done(500);
    check("rises1", rises[1], 32'd4);
    check("wide half", hi_len[1], 32'd10);
    check("ch0 untouched", rises[0], 32'd12);
    rd(PTG_ADR_CH1_TOTAL_LO, 16'h0004, "ch1 total");
    drv(1, 1'b0);
    $display("test wide done");
    setup(5'h00, 1'b0, 32'h0000_2000, 32'h0000_0000);
    drv(0, 1'b1);
    settle(800);
    check("endless busy", {31'h0, busy0}, 32'h1);
    wr(PTG_OFS_FREQ_LO, 16'h4000);
    settle(400);
    check("new half", hi_len[0], 32'd40);
    drv(0, 1'b0);
    settle(1);
    check("endless off", {31'h0, pulse0}, 32'h0);
    check("endless flag", {31'h0, done}, 32'h0);
    setup(C1, 1'b0, 32'h0000_2000, 32'h0000_0000);
    drv(1, 1'b1);
    settle(300);
    wr(C1 + PTG_OFS_CTRL, 16'h0002);
    settle(2);
    check("stop out", {30'h0, busy1, pulse1}, 32'h0);
    wr(C1 + PTG_OFS_CTRL, 16'h0000);
    drv(1, 1'b0);
    setup(5'h00, 1'b0, 32'h0000_2000, 32'h0000_0005);
    drv(0, 1'b1);
    settle(400);
    drv(0, 1'b0);
    settle(1);
    check("early stop", {29'h0, done, busy0, pulse0}, 32'h0);
    $display("test stop done");
    wr(PTG_ADR_CH0_TOTAL_LO, 16'h0000);
    wr(PTG_ADR_CH0_TOTAL_HI, 16'h0000);
    wr(PTG_ADR_BOTH_TOTAL_LO, 16'h0000);
    wr(PTG_ADR_BOTH_TOTAL_HI, 16'h0000);
    rd(PTG_ADR_CH0_TOTAL_LO, 16'h0000, "ch0 cleared");
    rd(PTG_ADR_BOTH_TOTAL_HI, 16'h0000, "both cleared");
    $display("test clear done");
    complete_run();
  end
  initial begin
    repeat (50000) @(posedge sys_clk);
    fail_count++;
    complete_run();
  end
endmodule : tb
